// ==== core/suspend_wake_cfg.svh ====
// Constants for the suspend and wake controller
`ifndef SUSPEND_WAKE_CFG_SVH
`define SUSPEND_WAKE_CFG_SVH
`define GPIO_COUNT 8
`define SETTLE_TIME_NS 2000
`define CLOCK_PERIOD_NS 10
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SETTLE_WIDTH 8
// Last count of the settle window, sized to the counter
`define SETTLE_LAST 8'hc7
`define GPIO_ZERO 8'h00
`define SETTLE_ZERO 8'h00
`define SETTLE_ONE 8'h01
`endif

// ==== core/suspend_wake_pkg.sv ====
// Types for the suspend and wake controller
package suspend_wake_pkg;
  typedef enum logic [1:0] {
    suspend_level_shallow = 2'h0,
    suspend_level_mid = 2'h1,
    suspend_level_deep = 2'h2
  } suspend_level_t;

  typedef enum logic [1:0] {
    st_run = 2'h0,
    st_suspended = 2'h1,
    st_settle = 2'h3
  } power_state_t;

  typedef struct packed {
    logic wake_frame;
    logic wol_frame;
    logic link_change;
  } net_wake_t;
endpackage : suspend_wake_pkg

// ==== core/wake_arm.sv ====
// Per-level arming of the network wake sources; GPIO wake stays armed at every level
`timescale 1ns/1ps
module wake_arm
  import suspend_wake_pkg::*;
(
  input wire suspend_level_t level,
  input wire net_wake_t net_enable,
  output logic arm_gpio,
  output net_wake_t arm_net
);
  always_comb begin
    arm_gpio = 1'b1;
    arm_net = '0;
    case (level)
      suspend_level_shallow: begin
        arm_net.wake_frame = net_enable.wake_frame;
        arm_net.wol_frame = net_enable.wol_frame;
      end
      suspend_level_mid: begin
        arm_net.link_change = net_enable.link_change;
      end
      default: begin
        arm_net = '0;
      end
    endcase
  end
endmodule : wake_arm

// ==== core/usb_suspend_wake_control.sv ====
// Suspend level selection, wake detection and clock gating
`timescale 1ns/1ps
`include "suspend_wake_cfg.svh"
module usb_suspend_wake_control
  import suspend_wake_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic level_load,
  input wire suspend_level_t level_select,
  input wire net_wake_t net_enable,
  input wire logic [`GPIO_COUNT-1:0] gpio_wake_enable,
  input wire logic [`GPIO_COUNT-1:0] gpio_in,
  input wire net_wake_t net_event,
  input wire logic suspend_request,
  input wire logic host_resume,
  output suspend_level_t level,
  output logic suspended,
  output logic module_clock_enable,
  output logic mac_run,
  output logic remote_wakeup
);
  // ----------------------------------------
  // Arming
  // ----------------------------------------
  logic arm_gpio;
  net_wake_t arm_net;
  wake_arm wake_arm_inst (
    .level(level),
    .net_enable(net_enable),
    .arm_gpio(arm_gpio),
    .arm_net(arm_net)
  );

  // ----------------------------------------
  // Registers and next values
  // ----------------------------------------
  power_state_t state;
  power_state_t next_state;
  suspend_level_t next_level;
  logic [`GPIO_COUNT-1:0] gpio_last;
  logic [`GPIO_COUNT-1:0] next_gpio_last;
  logic [`SETTLE_WIDTH-1:0] settle;
  logic [`SETTLE_WIDTH-1:0] next_settle;
  logic next_suspended;
  logic next_module_clock_enable;
  logic next_mac_run;
  logic next_remote_wakeup;

  // ----------------------------------------
  // Wake detection
  // ----------------------------------------
  logic [`GPIO_COUNT-1:0] gpio_rise;
  logic gpio_hit;
  logic net_hit;
  logic wake_hit;
  logic resume_hit;
  logic settle_done;

  always_comb begin
    // Rising edge only, so a pin held high at entry does not wake at once
    gpio_rise = gpio_in & ~gpio_last & gpio_wake_enable;
    gpio_hit = arm_gpio && (|gpio_rise);
    // Arming already masks the sources that the level leaves out
    net_hit = |(arm_net & net_event);
    wake_hit = gpio_hit || net_hit;
    resume_hit = host_resume || wake_hit;
    settle_done = (settle == `SETTLE_LAST);
  end

  // ----------------------------------------
  // Pin history
  // ----------------------------------------
  always_comb begin
    next_gpio_last = gpio_in;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gpio_last <= `GPIO_ZERO;
    end else begin
      gpio_last <= next_gpio_last;
    end
  end

  // ----------------------------------------
  // Suspend level
  // ----------------------------------------
  always_comb begin
    next_level = level;
    // Changing level mid-suspend would rearm sources behind the host
    if (level_load && (state == st_run)) begin
      next_level = level_select;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      level <= suspend_level_deep;
    end else begin
      level <= next_level;
    end
  end

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (suspend_request) begin
          next_state = st_suspended;
        end
      end
      st_suspended: begin
        if (resume_hit) begin
          next_state = st_settle;
        end
      end
      st_settle: begin
        if (settle_done) begin
          next_state = st_run;
        end
      end
      default: begin
        next_state = st_run;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_run;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Settle counter
  // ----------------------------------------
  always_comb begin
    next_settle = settle;
    case (state)
      st_suspended: begin
        next_settle = `SETTLE_ZERO;
      end
      st_settle: begin
        if (!settle_done) begin
          next_settle = settle + `SETTLE_ONE;
        end
      end
      default: begin
        next_settle = `SETTLE_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settle <= `SETTLE_ZERO;
    end else begin
      settle <= next_settle;
    end
  end

  // ----------------------------------------
  // Wake request
  // ----------------------------------------
  always_comb begin
    next_remote_wakeup = 1'b0;
    // Host resume wins; a host-led resume needs no wake request
    if ((state == st_suspended) && wake_hit && !host_resume) begin
      next_remote_wakeup = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      remote_wakeup <= 1'b0;
    end else begin
      remote_wakeup <= next_remote_wakeup;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_comb begin
    next_suspended = (next_state == st_suspended);
    // Clocks stop in every level; deeper levels also cut supplies outside this block
    next_module_clock_enable = (next_state != st_suspended);
    // MAC held through settle so it never sees an unsteady clock
    next_mac_run = (next_state == st_run);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      suspended <= 1'b0;
      module_clock_enable <= 1'b1;
      mac_run <= 1'b1;
    end else begin
      suspended <= next_suspended;
      module_clock_enable <= next_module_clock_enable;
      mac_run <= next_mac_run;
    end
  end
endmodule : usb_suspend_wake_control

// ==== testbench/wake_checker_sva.sv ====
// Assertion checker for the suspend and wake controller
`timescale 1ns/1ps
module wake_checker import suspend_wake_pkg::*; (
  input wire logic clock, reset_n, level_load, suspend_request, host_resume,
  input wire suspend_level_t level_select, level,
  input wire net_wake_t net_enable, net_event,
  input wire logic [7:0] gpio_wake_enable, gpio_in,
  input wire logic suspended, module_clock_enable, mac_run, remote_wakeup
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Host resume wins, so it masks wake checks
  wire armed = suspended && !host_resume;
  rst_deep_a: assert property ($rose(reset_n) |-> level == suspend_level_deep) else $error("level");
  level_load_a: assert property (level_load && mac_run && level_select != 2'h3 |=> level == $past(level_select))
    else $error("load");
  gate_on_a: assert property (suspend_request && mac_run |=> suspended && !module_clock_enable && !mac_run)
    else $error("gate");
  shallow_net_a: assert property (armed && level == suspend_level_shallow && |(net_enable[2:1] & net_event[2:1])
    |=> remote_wakeup) else $error("shallow");
  mid_link_a: assert property (armed && level == suspend_level_mid && net_enable[0] && net_event[0]
    |=> remote_wakeup) else $error("mid");
  deep_quiet_a: assert property (suspended && level == suspend_level_deep && $stable(gpio_in)
    |=> !remote_wakeup) else $error("deep");
  pin_wake_a: assert property (armed && |(gpio_in & ~$past(gpio_in) & gpio_wake_enable)
    |=> remote_wakeup && !suspended) else $error("pin");
  settle_a: assert property ($fell(suspended) |-> ##199 !mac_run ##1 mac_run) else $error("settle");
  cover property (remote_wakeup);
  cover property ($rose(mac_run));
  cover property (suspended && host_resume);
endmodule : wake_checker
bind usb_suspend_wake_control wake_checker wake_checker_inst (.*);

// ==== testbench/host_model.sv ====
// Upstream host model giving a resume
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  input wire logic ask,
  output logic host_resume
);
  initial host_resume = 1'b0;
  // Launched just after an edge, one cycle long
  always @(posedge clock) host_resume <= ask;
endmodule : host_model

// ==== testbench/usb_suspend_wake_control_bench.sv ====
// Bench for the suspend and wake controller
`timescale 1ns/1ps
module usb_suspend_wake_control_bench import suspend_wake_pkg::*; ;
  logic clock = 0, reset_n = 0, level_load = 0, suspend_request = 0, ask = 0;
  suspend_level_t level_select = suspend_level_deep, level;
  net_wake_t net_enable = 3'h7, net_event = 3'h0;
  logic [7:0] gpio_wake_enable = 8'hff, gpio_in = 8'h00;
  logic host_resume, suspended, module_clock_enable, mac_run, remote_wakeup;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  always #5 clock = ~clock;
  host_model host_model_inst (.clock(clock), .ask(ask), .host_resume(host_resume));
  usb_suspend_wake_control usb_suspend_wake_control_inst (
    .clock(clock),
    .reset_n(reset_n),
    .level_load(level_load),
    .level_select(level_select),
    .net_enable(net_enable),
    .gpio_wake_enable(gpio_wake_enable),
    .gpio_in(gpio_in),
    .net_event(net_event),
    .suspend_request(suspend_request),
    .host_resume(host_resume),
    .level(level),
    .suspended(suspended),
    .module_clock_enable(module_clock_enable),
    .mac_run(mac_run),
    .remote_wakeup(remote_wakeup)
  );
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // Unwoken cases leave suspend through the host
  task automatic go(suspend_level_t l, net_wake_t e, logic [7:0] g, logic w);
    @(posedge clock) level_load <= 1;
    level_select <= l;
    @(posedge clock) level_load <= 0;
    suspend_request <= 1;
    @(posedge clock) suspend_request <= 0;
    @(posedge clock) net_event <= e;
    gpio_in <= g;
    #1 chk({suspended, module_clock_enable}, 8'h2);
    @(posedge clock) net_event <= 0;
    gpio_in <= 0;
    ask <= !w;
    #1 chk(remote_wakeup, w);
    @(posedge clock) ask <= 0;
    repeat (300) if (!mac_run) @(posedge clock);
    #1 chk({level, mac_run, module_clock_enable, suspended}, {l, 3'h6});
    $display("test done level %0d", l);
  endtask : go
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1;
    #1 chk(level, suspend_level_deep);
    go(suspend_level_shallow, 3'h4, 8'h00, 1);
    go(suspend_level_mid, 3'h1, 8'h00, 1);
    go(suspend_level_mid, 3'h2, 8'h00, 0);
    go(suspend_level_deep, 3'h7, 8'h00, 0);
    go(suspend_level_deep, 3'h0, 8'h80, 1);
    go(suspend_level_shallow, 3'h2, 8'h00, 1);
    go(suspend_level_t'(2'h3), 3'h7, 8'h00, 0);
    @(posedge clock) net_enable <= 3'h0;
    gpio_wake_enable <= 8'h7f;
    go(suspend_level_shallow, 3'h7, 8'h80, 0);
    close_out();
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
endmodule : usb_suspend_wake_control_bench
